/* logic/cxia_pkg.sv */
// package for the cpu exception and interrupt acknowledge unit
package cxia_pkg;
    // register word offsets on the avalon slave
    localparam logic [3:0] OFF_ISP     = 4'h0;
    localparam logic [3:0] OFF_PSW     = 4'h1;
    localparam logic [3:0] OFF_SWPC    = 4'h2;
    localparam logic [3:0] OFF_SWPSW   = 4'h3;
    localparam logic [3:0] OFF_CAUSE   = 4'h4;
    localparam logic [3:0] OFF_FPC     = 4'h5;
    localparam logic [3:0] OFF_FPSW    = 4'h6;
    localparam logic [3:0] OFF_IRQST   = 4'h7;
    localparam logic [3:0] OFF_IRQMSK  = 4'h8;
    localparam logic [3:0] OFF_CTRL    = 4'h9;
    localparam logic [31:0] ISP_CPU_ADDR = 32'hfffff1fa;
    localparam logic [7:0]  ISP_RESET    = 8'h00;
    // status word bit positions
    localparam int PSW_MASK_BIT = 5;
    localparam int PSW_EXC_BIT  = 6;
    localparam int PSW_NMI_BIT  = 7;
    localparam logic [31:0] PSW_RESET  = 32'h00000020;
    localparam logic [31:0] VEC_SW_LO  = 32'h00000040;
    localparam logic [31:0] VEC_SW_HI  = 32'h00000050;
    localparam logic [31:0] VEC_FAULT  = 32'h00000060;
    localparam logic [4:0]  SW_VEC_SPLIT = 5'h10;
    localparam logic [15:0] SW_CAUSE_BASE = 16'h0040;
    localparam logic [4:0]  PSW_SREG_ID = 5'h05;
    localparam logic [23:0] STORE_WIN_A = 24'hfff100;
    localparam logic [23:0] STORE_WIN_B = 24'hfff900;
    localparam logic [5:0]  BADOP_LOW   = 6'h3f;
    localparam logic [3:0]  BADOP_MIDLO = 4'h7;
    // response time
    localparam int RESP_NS = 20;
    localparam int CLK_NS  = 4;
    localparam int RESP_CYC = (RESP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_PULSE_CYC = 16;
    // interrupt status bits
    localparam int EV_SWEXC = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_ACK   = 2;
    localparam int EV_NUM   = 3;

    typedef enum logic [2:0] {
        CX_NONE, CX_TRAP, CX_RETURN, CX_MASK, CX_UNMASK, CX_SRLOAD, CX_STORE, CX_OTHER
    } cxia_op_t;

    // one retiring instruction from the pipeline
    typedef struct packed {
        logic        valid;
        cxia_op_t    op;
        logic [31:0] word;
        logic [31:0] nextPc;
        logic [31:0] storeAddr;
        logic [4:0]  sregId;
        logic [31:0] sregData;
    } cxia_instr_t;

    // redirect to the pipeline
    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
    } cxia_redirect_t;
endpackage : cxia_pkg

/* logic/cxia_prio_pick.sv */
// lowest-index set bit finder, used for highest-priority selection
`timescale 1ns/1ps
module cxia_prio_pick #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] reqVec,
    output logic      [WIDTH-1:0] oneHot,
    output logic                  any
);
    initial begin
        if (WIDTH < 1) begin
            $error("cxia_prio_pick: width must be positive");
        end
    end

    always_comb begin
        oneHot = '0;
        any    = 1'b0;
        for (int i = 0; i < WIDTH; i++) begin
            if (reqVec[i] && !any) begin
                oneHot[i] = 1'b1;
                any       = 1'b1;
            end
        end
    end
endmodule : cxia_prio_pick

/* logic/cxia_exc_unit.sv */
// cpu exception and interrupt acknowledge unit with avalon register slave
//
// Function
// - in-service byte, bit n marks level n
// - mask flag at status bit 5 gates requests
// - trap raises exception, never masked
// - trap saves pc, status, cause; sets flags
// - trap vector 40h below 10h, else 50h
// - exception return reloads pc, status from trap save
// - illegal opcode bit pattern decode
// - illegal next instruction raises fault trap
// - fault saves pc, status; sets flags; 60h
// - no fault return; reset output pulse
// - interrupt response at least five clocks
// - no acknowledge after non-sampling instruction
// - mask, unmask, status load, window stores
// - return clears lowest-index set in-service bit
// - nmi or exception return keeps in-service
// - in-service register read only
`timescale 1ns/1ps
module cxia_exc_unit #(
    parameter int LEVELS = 8
) (
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    input  wire logic [3:0]               avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output logic      [31:0]              avs_readdata,
    output logic                          avs_waitrequest,
    input  wire cxia_pkg::cxia_instr_t    instr,
    input  wire logic                     irqReq,
    input  wire logic [2:0]               irqLevel,
    input  wire logic                     stopMode,
    input  wire logic                     extBusBusy,
    output logic                          irqAck,
    output cxia_pkg::cxia_redirect_t      redirect,
    output logic                          systemResetOutN,
    output logic      [31:0]              programStatusWord,
    output logic                          irqOut
);
    initial begin
        if (LEVELS != 8) begin
            $error("cxia_exc_unit: eight priority levels only");
        end
    end

    logic [LEVELS-1:0] inService_q;
    logic [31:0] psw_q, swPc_q, swPsw_q, cause_q, faultPc_q, faultPsw_q;
    logic [cxia_pkg::EV_NUM-1:0] irqSt_q, irqMsk_q, evSet;
    logic [2:0]  respCnt_q;
    logic        holdOff_q, faulted_q, rdPend_q, swVecMap_q;
    logic [4:0]  rstCnt_q;
    logic [31:0] rdData_q;

    function automatic logic isBadOpcode(input logic [31:0] w);
        return (w[10:5] == cxia_pkg::BADOP_LOW) &&
               (w[26:23] >= cxia_pkg::BADOP_MIDLO) && !w[16];
    endfunction : isBadOpcode

    function automatic logic inStoreWin(input logic [31:0] a);
        return (a[23:8] == cxia_pkg::STORE_WIN_A[23:8]) ||
               (a[23:8] == cxia_pkg::STORE_WIN_B[23:8]);
    endfunction : inStoreWin

    wire logic takeInstr = instr.valid && !faulted_q;
    wire logic badOp     = takeInstr && isBadOpcode(instr.word);
    wire logic doTrap    = takeInstr && !badOp && instr.op == cxia_pkg::CX_TRAP;
    wire logic doReturn  = takeInstr && !badOp && instr.op == cxia_pkg::CX_RETURN;
    wire logic nonSample = takeInstr && !badOp &&
        (instr.op == cxia_pkg::CX_MASK || instr.op == cxia_pkg::CX_UNMASK ||
         (instr.op == cxia_pkg::CX_SRLOAD && instr.sregId == cxia_pkg::PSW_SREG_ID) ||
         (instr.op == cxia_pkg::CX_STORE && inStoreWin(instr.storeAddr)));
    wire logic retFromSw = doReturn && psw_q[cxia_pkg::PSW_EXC_BIT];

    // level-n pick for the return clear
    logic [LEVELS-1:0] topBit;
    logic              anyInService;
    cxia_prio_pick #(.WIDTH(LEVELS)) uPick (
        .reqVec (inService_q),
        .oneHot (topBit),
        .any    (anyInService)
    );

    // interrupt acknowledge: response counter, mask, hold-off
    wire logic irqBlocked = stopMode || extBusBusy || holdOff_q || nonSample ||
                            badOp || doTrap || doReturn || faulted_q;
    assign irqAck = irqReq && respCnt_q == 3'(cxia_pkg::RESP_CYC - 1) &&
                    !psw_q[cxia_pkg::PSW_MASK_BIT] && !irqBlocked;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            respCnt_q <= '0;
        end else if (!irqReq || irqAck) begin
            respCnt_q <= '0;
        end else if (respCnt_q != 3'(cxia_pkg::RESP_CYC - 1)) begin
            respCnt_q <= respCnt_q + 3'h1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            holdOff_q <= 1'b0;
        end else if (takeInstr) begin
            holdOff_q <= nonSample;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            inService_q <= cxia_pkg::ISP_RESET;
        end else if (irqAck) begin
            inService_q <= inService_q | (LEVELS'(1) << irqLevel);
        end else if (doReturn && !psw_q[cxia_pkg::PSW_EXC_BIT] &&
                     !psw_q[cxia_pkg::PSW_NMI_BIT]) begin
            inService_q <= inService_q & ~topBit;
        end
    end

    // status word and save registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            psw_q      <= cxia_pkg::PSW_RESET;
            swPc_q     <= '0;
            swPsw_q    <= '0;
            cause_q    <= '0;
            faultPc_q  <= '0;
            faultPsw_q <= '0;
        end else if (badOp) begin
            faultPc_q  <= instr.nextPc;
            faultPsw_q <= psw_q;
            psw_q[cxia_pkg::PSW_NMI_BIT]  <= 1'b1;
            psw_q[cxia_pkg::PSW_EXC_BIT]  <= 1'b1;
            psw_q[cxia_pkg::PSW_MASK_BIT] <= 1'b1;
        end else if (doTrap) begin
            swPc_q        <= instr.nextPc;
            swPsw_q       <= psw_q;
            cause_q[15:0] <= cxia_pkg::SW_CAUSE_BASE | 16'(instr.word[4:0]);
            psw_q[cxia_pkg::PSW_EXC_BIT]  <= 1'b1;
            psw_q[cxia_pkg::PSW_MASK_BIT] <= 1'b1;
        end else if (retFromSw) begin
            psw_q <= swPsw_q;
        end else if (irqAck) begin
            psw_q[cxia_pkg::PSW_MASK_BIT] <= 1'b1;
        end else if (takeInstr && instr.op == cxia_pkg::CX_MASK) begin
            psw_q[cxia_pkg::PSW_MASK_BIT] <= 1'b1;
        end else if (takeInstr && instr.op == cxia_pkg::CX_UNMASK) begin
            psw_q[cxia_pkg::PSW_MASK_BIT] <= 1'b0;
        end else if (takeInstr && instr.op == cxia_pkg::CX_SRLOAD &&
                     instr.sregId == cxia_pkg::PSW_SREG_ID) begin
            psw_q <= instr.sregData;
        end
    end

    // redirect to the pipeline
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            redirect <= '0;
        end else begin
            redirect.valid <= badOp || doTrap || retFromSw;
            if (badOp) begin
                redirect.pc <= cxia_pkg::VEC_FAULT;
            end else if (doTrap) begin
                redirect.pc <= (instr.word[4:0] < cxia_pkg::SW_VEC_SPLIT) ?
                               cxia_pkg::VEC_SW_LO : cxia_pkg::VEC_SW_HI;
            end else if (retFromSw) begin
                redirect.pc <= swPc_q;
            end
        end
    end

    // fault lock and reset pulse; only the system reset leaves it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            faulted_q <= 1'b0;
            rstCnt_q  <= '0;
        end else if (badOp) begin
            faulted_q <= 1'b1;
            rstCnt_q  <= 5'(cxia_pkg::RESET_PULSE_CYC);
        end else if (rstCnt_q != 5'h0) begin
            rstCnt_q <= rstCnt_q - 5'h1;
        end
    end
    assign systemResetOutN   = (rstCnt_q == 5'h0);
    assign programStatusWord = psw_q;

    // sticky event status, set wins over write-one clear
    assign evSet = {irqAck, badOp, doTrap};
    wire logic wrHit = avs_write && !avs_waitrequest;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irqSt_q <= '0;
        end else begin
            irqSt_q <= (irqSt_q & ~((wrHit && avs_address == cxia_pkg::OFF_IRQST &&
                       avs_byteenable[0]) ? avs_writedata[cxia_pkg::EV_NUM-1:0] : '0))
                       | evSet;
        end
    end
    assign irqOut = |(irqSt_q & irqMsk_q);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irqMsk_q   <= '0;
            swVecMap_q <= 1'b0;
        end else if (wrHit && avs_byteenable[0]) begin
            if (avs_address == cxia_pkg::OFF_IRQMSK) begin
                irqMsk_q <= avs_writedata[cxia_pkg::EV_NUM-1:0];
            end
            if (avs_address == cxia_pkg::OFF_CTRL) begin
                swVecMap_q <= avs_writedata[0];
            end
        end
    end

    // reads answer one cycle after the request; writes take no wait
    assign avs_waitrequest = avs_read && !rdPend_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdPend_q <= 1'b0;
            rdData_q <= '0;
        end else begin
            rdPend_q <= avs_read && !rdPend_q;
            unique case (avs_address)
                cxia_pkg::OFF_ISP:    rdData_q <= 32'(inService_q);
                cxia_pkg::OFF_PSW:    rdData_q <= psw_q;
                cxia_pkg::OFF_SWPC:   rdData_q <= swPc_q;
                cxia_pkg::OFF_SWPSW:  rdData_q <= swPsw_q;
                cxia_pkg::OFF_CAUSE:  rdData_q <= cause_q;
                cxia_pkg::OFF_FPC:    rdData_q <= faultPc_q;
                cxia_pkg::OFF_FPSW:   rdData_q <= faultPsw_q;
                cxia_pkg::OFF_IRQST:  rdData_q <= 32'(irqSt_q);
                cxia_pkg::OFF_IRQMSK: rdData_q <= 32'(irqMsk_q);
                cxia_pkg::OFF_CTRL:   rdData_q <= {31'h0, swVecMap_q};
                default:              rdData_q <= 32'h0;
            endcase
        end
    end
    assign avs_readdata = rdData_q;
endmodule : cxia_exc_unit

/* verification/cxia_chk.sv */
// concurrent checks on the ports of the exception unit
`timescale 1ns/1ps
module cxia_chk (
    input wire logic                     core_clk,
    input wire logic                     resetn,
    input wire cxia_pkg::cxia_instr_t    instr,
    input wire logic                     irqReq,
    input wire logic                     stopMode,
    input wire logic                     extBusBusy,
    input wire logic                     irqAck,
    input wire cxia_pkg::cxia_redirect_t redirect,
    input wire logic                     systemResetOutN,
    input wire logic [31:0]              programStatusWord
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    logic [31:0] w;
    logic        live;
    logic        bad;
    logic        ns;
    assign w = instr.word;
    assign live = instr.valid && !programStatusWord[7];
    assign bad = w[10:5] == 6'h3f && w[26:23] >= 4'h7 && !w[16];
    assign ns = instr.valid && instr.op inside {cxia_pkg::CX_MASK, cxia_pkg::CX_UNMASK};
    property p_trap;
        live && !bad && instr.op == cxia_pkg::CX_TRAP |=> redirect.valid
            && redirect.pc == ($past(w[4]) ? 32'h50 : 32'h40) && programStatusWord[6:5] == 2'h3;
    endproperty
    a_trap: assert property (p_trap) else $error("trap redirect wrong");
    property p_fault;
        live && bad |=> redirect.valid && redirect.pc == 32'h60 && programStatusWord[7:5] == 3'h7;
    endproperty
    a_fault: assert property (p_fault) else $error("fault redirect wrong");
    property p_rst;
        live && bad |=> !systemResetOutN [*8];
    endproperty
    a_rst: assert property (p_rst) else $error("reset pulse short");
    property p_ret;
        live && instr.op == cxia_pkg::CX_RETURN && programStatusWord[6] |=> redirect.valid;
    endproperty
    a_ret: assert property (p_ret) else $error("return not redirected");
    property p_resp;
        irqAck |-> $past(irqReq, 4) && $past(irqReq, 3) && $past(irqReq, 2) && $past(irqReq);
    endproperty
    a_resp: assert property (p_resp) else $error("acknowledge too early");
    property p_gate;
        irqAck |-> !programStatusWord[5] && !stopMode && !extBusBusy;
    endproperty
    a_gate: assert property (p_gate) else $error("acknowledge while blocked");
    property p_nons;
        irqAck |-> !ns && !$past(ns);
    endproperty
    a_nons: assert property (p_nons) else $error("acknowledge after mask op");
    property p_ack;
        irqAck |=> programStatusWord[5];
    endproperty
    a_ack: assert property (p_ack) else $error("mask flag not set");
endmodule : cxia_chk
bind cxia_exc_unit cxia_chk chk_u (.core_clk, .resetn, .instr, .irqReq, .stopMode, .extBusBusy,
    .irqAck, .redirect, .systemResetOutN, .programStatusWord);

/* verification/cxia_irq_src.sv */
// interrupt source model: holds a request until taken, then rests
`timescale 1ns/1ps
module cxia_irq_src (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       fire,
    input  wire logic [2:0] lvl,
    input  wire logic       irqAck,
    output logic            irqReq,
    output logic      [2:0] irqLevel
);
    logic [2:0] gap_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irqReq <= 1'b0;
            irqLevel <= 3'h7;
            gap_q <= 3'h0;
        end else if (irqReq) begin
            if (irqAck) begin
                irqReq <= 1'b0;
                irqLevel <= ~irqLevel;
                gap_q <= 3'h5;
            end
        end else if (gap_q != 3'h0) begin
            gap_q <= gap_q - 3'h1;
        end else if (fire) begin
            irqReq <= 1'b1;
            irqLevel <= lvl;
        end
    end
endmodule : cxia_irq_src

/* verification/test_cpu_exception_interrupt_ack.sv */
// register and instruction sequence bench for the exception unit
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module test_cpu_exception_interrupt_ack;
    logic                     core_clk, resetn, avs_read, avs_write, avs_waitrequest;
    logic [3:0]               avs_address, avs_byteenable;
    logic [31:0]              avs_writedata, avs_readdata, programStatusWord, d, p;
    cxia_pkg::cxia_instr_t    instr;
    cxia_pkg::cxia_redirect_t redirect;
    logic                     irqReq, stopMode, extBusBusy, irqAck, systemResetOutN, irqOut, fire;
    logic [2:0]               irqLevel, lvl;
    int                       n_fail, cmp_count, nLow;
    cxia_exc_unit dut_u (.core_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .instr, .irqReq, .irqLevel, .stopMode,
        .extBusBusy, .irqAck, .redirect, .systemResetOutN, .programStatusWord, .irqOut);
    cxia_irq_src src_u (.core_clk, .resetn, .fire, .lvl, .irqAck, .irqReq, .irqLevel);
    always @(negedge core_clk) if (systemResetOutN === 1'b0) nLow++;
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    task automatic acc(input logic [3:0] a, input logic wt, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= wd;
        if (wt) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        // sampled right after the edge: these are the values the slave saw
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            test_done();
        end
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : acc
    task automatic ex(input cxia_pkg::cxia_op_t op, input logic [31:0] wd);
        instr <= '{1'b1, op, wd, 32'h1000 + wd, 32'h0, 5'h0, 32'h0};
        @(posedge core_clk);
        instr.valid <= 1'b0;
        @(posedge core_clk);
    endtask : ex
    // st: cycles the blocker stays up; h: cycle of the instruction that ends hold-off
    task automatic irq(input logic [2:0] l, input int st, input int h, input logic bus);
        int n, e;
        n = 0;
        e = 5;
        if (st + 1 > e) e = st + 1;
        if (h + 2 > e) e = h + 2;
        lvl <= l;
        fire <= 1'b1;
        stopMode <= (st > 0) && !bus;
        extBusBusy <= (st > 0) && bus;
        do begin
            @(posedge core_clk);
            instr <= '{n == h, cxia_pkg::CX_NONE, 32'h0, 32'h0, 32'h0, 5'h0, 32'h0};
            if (n == st) begin
                stopMode <= 1'b0;
                extBusBusy <= 1'b0;
            end
            n++;
            @(negedge core_clk);
        end while (irqAck !== 1'b1 && n < 60);
        `CHK(n, e)
        if (irqAck !== 1'b1) test_done();
        @(posedge core_clk);
        fire <= 1'b0;
    endtask : irq
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        test_done();
    end
    initial begin
        {resetn, avs_read, avs_write, stopMode, extBusBusy, fire, lvl} = '0;
        {avs_address, avs_writedata, instr, n_fail, cmp_count, nLow} = '0;
        avs_byteenable = 4'hf;
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        acc(cxia_pkg::OFF_ISP, 1'b0, 0); `CHK(d, 32'h0)
        acc(cxia_pkg::OFF_PSW, 1'b0, 0); `CHK(d, 32'h20)
        acc(cxia_pkg::OFF_ISP, 1'b1, 32'hff);
        acc(cxia_pkg::OFF_ISP, 1'b0, 0); `CHK(d, 32'h0)
        acc(4'hf, 1'b0, 0); `CHK(d, 32'h0)
        acc(cxia_pkg::OFF_CTRL, 1'b1, 32'h1);
        acc(cxia_pkg::OFF_CTRL, 1'b0, 0); `CHK(d, 32'h1)
        acc(cxia_pkg::OFF_IRQMSK, 1'b1, 32'h7);
        for (int i = 0; i < 2; i++) begin
            ex(cxia_pkg::CX_TRAP, 32'h0f + i);
            acc(cxia_pkg::OFF_CAUSE, 1'b0, 0); `CHK(d[15:0], 16'h004f + i)
            acc(cxia_pkg::OFF_SWPC, 1'b0, 0); `CHK(d, 32'h100f + i)
            acc(cxia_pkg::OFF_SWPSW, 1'b0, 0); `CHK(d, 32'h20)
            acc(cxia_pkg::OFF_PSW, 1'b0, 0); `CHK(d[6:5], 2'h3)
            ex(cxia_pkg::CX_RETURN, 0);
            acc(cxia_pkg::OFF_PSW, 1'b0, 0); `CHK(d, 32'h20)
        end
        `CHK(irqOut, 1'b1)
        acc(cxia_pkg::OFF_IRQMSK, 1'b1, 32'h0); `CHK(irqOut, 1'b0)
        acc(cxia_pkg::OFF_IRQMSK, 1'b1, 32'h7);
        acc(cxia_pkg::OFF_IRQST, 1'b1, 32'h1);
        acc(cxia_pkg::OFF_IRQST, 1'b0, 0); `CHK(d[2:0], 3'h0)
        ex(cxia_pkg::CX_UNMASK, 0);
        irq(3'h3, 0, 4, 1'b0);
        acc(cxia_pkg::OFF_ISP, 1'b0, 0); `CHK(d, 32'h08)
        acc(cxia_pkg::OFF_PSW, 1'b0, 0); `CHK(d[5], 1'b1)
        acc(cxia_pkg::OFF_IRQST, 1'b0, 0); `CHK(d[2], 1'b1)
        ex(cxia_pkg::CX_UNMASK, 0);
        irq(3'h1, 12, 0, 1'b0);
        acc(cxia_pkg::OFF_ISP, 1'b0, 0); `CHK(d, 32'h0a)
        ex(cxia_pkg::CX_RETURN, 0);
        acc(cxia_pkg::OFF_ISP, 1'b0, 0); `CHK(d, 32'h08)
        ex(cxia_pkg::CX_TRAP, 32'h05);
        ex(cxia_pkg::CX_RETURN, 0);
        acc(cxia_pkg::OFF_ISP, 1'b0, 0); `CHK(d, 32'h08)
        ex(cxia_pkg::CX_OTHER, 32'h038107e0);
        acc(cxia_pkg::OFF_PSW, 1'b0, 0); `CHK(d[7], 1'b0)
        p = d;
        ex(cxia_pkg::CX_OTHER, 32'h038007e0);
        acc(cxia_pkg::OFF_FPC, 1'b0, 0); `CHK(d, 32'h038017e0)
        acc(cxia_pkg::OFF_FPSW, 1'b0, 0); `CHK(d, p)
        acc(cxia_pkg::OFF_PSW, 1'b0, 0); `CHK(d[7:5], 3'h7)
        ex(cxia_pkg::CX_TRAP, 32'h01);
        acc(cxia_pkg::OFF_CAUSE, 1'b0, 0); `CHK(d[15:0], 16'h0045)
        repeat (24) @(posedge core_clk);
        `CHK(nLow, 16)
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        acc(cxia_pkg::OFF_PSW, 1'b0, 0); `CHK(d, 32'h20)
        ex(cxia_pkg::CX_TRAP, 32'h12);
        acc(cxia_pkg::OFF_CAUSE, 1'b0, 0); `CHK(d[15:0], 16'h0052)
        ex(cxia_pkg::CX_UNMASK, 0);
        irq(3'h2, 10, 0, 1'b1);
        acc(cxia_pkg::OFF_ISP, 1'b0, 0); `CHK(d, 32'h04)
        test_done();
    end
endmodule : test_cpu_exception_interrupt_ack
